// ### core/recap_pkg.sv
// recap_pkg: offsets, field positions, widths and reset values for the
// extended capability register bank.
// assumes a 32-bit register port with byte addresses and word-aligned access.
package recap_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // byte offsets
    localparam logic [ADDR_W-1:0] OFS_CAP_LO = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_CAP_HI = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_ACC_STAT = 12'h020;

    // field positions in the 64-bit capability value
    localparam int POS_WALK_SNOOPED = 0;
    localparam int POS_QUEUED_INV = 1;
    localparam int POS_DEVICE_TLB = 2;
    localparam int POS_INTR_REMAP = 3;
    localparam int POS_WIDE_INTR_ID = 4;
    localparam int POS_PASS_THROUGH = 6;
    localparam int POS_SNOOP_CTRL = 7;
    localparam int POS_IOTLB_OFS_LO = 8;
    localparam int IOTLB_OFS_W = 10;
    localparam int POS_HANDLE_MASK_LO = 20;
    localparam int HANDLE_MASK_W = 4;
    localparam int POS_EXT_CONTEXT = 24;
    localparam int POS_MEM_TYPE = 25;
    localparam int POS_PAGE_REQ = 29;
    localparam int POS_PASID = 40;

    // iotlb group spacing: one unit of the offset field is 16 bytes
    localparam int IOTLB_UNIT_SHIFT = 4;
    localparam int IOTLB_BASE_W = IOTLB_OFS_W + IOTLB_UNIT_SHIFT;

    // access status register bits
    localparam int POS_STAT_RO_WRITE = 0;
    localparam int POS_STAT_UNMAPPED = 1;
    localparam int STAT_W = 2;

    // reset values
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    localparam logic [63:0] CAP_RST = 64'h0000_0000_0000_0000;

endpackage

// ### core/recap_fields.sv
// recap_fields: assembles the fixed 64-bit capability value from the
// implementation parameters and holds it in flip-flops.
// assumes the parameters were already checked for consistency by the top.
`timescale 1ns/1ns
module recap_fields
    import recap_pkg::*;
#(
    parameter bit WALK_SNOOPED = 1'b1,
    parameter bit QUEUED_INV = 1'b1,
    parameter bit DEVICE_TLB = 1'b1,
    parameter bit INTR_REMAP = 1'b1,
    parameter bit WIDE_INTR_ID = 1'b0,
    parameter bit PASS_THROUGH = 1'b1,
    parameter bit SNOOP_CTRL = 1'b1,
    parameter logic [IOTLB_OFS_W-1:0] IOTLB_OFS = 10'h020,
    parameter logic [HANDLE_MASK_W-1:0] HANDLE_MASK = 4'hf,
    parameter bit EXT_CONTEXT = 1'b1,
    parameter bit MEM_TYPE = 1'b1,
    parameter bit PAGE_REQ = 1'b0,
    parameter bit PASID = 1'b0
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // fixed value
    output logic [63:0] o_cap
);

    logic [63:0] cap_fixed;

    // reserved bits stay zero, including bit 5 and bits 19:18
    always_comb begin
        cap_fixed = 64'h0000_0000_0000_0000;
        cap_fixed[POS_WALK_SNOOPED] = WALK_SNOOPED;
        cap_fixed[POS_QUEUED_INV] = QUEUED_INV;
        cap_fixed[POS_DEVICE_TLB] = DEVICE_TLB;
        cap_fixed[POS_INTR_REMAP] = INTR_REMAP;
        cap_fixed[POS_WIDE_INTR_ID] = WIDE_INTR_ID;
        cap_fixed[POS_PASS_THROUGH] = PASS_THROUGH;
        cap_fixed[POS_SNOOP_CTRL] = SNOOP_CTRL;
        cap_fixed[POS_IOTLB_OFS_LO +: IOTLB_OFS_W] = IOTLB_OFS;
        cap_fixed[POS_HANDLE_MASK_LO +: HANDLE_MASK_W] = HANDLE_MASK;
        cap_fixed[POS_EXT_CONTEXT] = EXT_CONTEXT;
        cap_fixed[POS_MEM_TYPE] = MEM_TYPE;
        cap_fixed[POS_PAGE_REQ] = PAGE_REQ;
        cap_fixed[POS_PASID] = PASID;
    end

    // held in flops so a read path sees a registered source
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cap <= CAP_RST;
        end else begin
            o_cap <= cap_fixed;
        end
    end

endmodule

// ### core/recap_top.sv
// recap_top: read-only extended capability register bank of the remapping
// unit, with its access status register and fixed coherency controls.
// assumes a single-cycle register master; read data valid one cycle later.
// assumes every capability parameter is fixed at build time, so software
// can only read the value and clear the access status flags.
//
// Behaviour
// - the capability register sits at byte offset 010h from the unit base.
// - bit 25 reports memory type support, meaningful with pasid and ext ctx.
// - a unit covering coherent-domain devices reports memory type as 1.
// - bit 24 reports extended context; forced by pasid or page requests.
// - bits 23:20 hold the largest interrupt mask in cache invalidations.
// - bits 17:8 hold y, and the iotlb group sits at base plus 16 times y.
// - bit 7 reports whether a set snoop attribute in pte is honoured.
// - snoop control is recommended and is on by default.
// - bit 6 reports pass-through translation support.
// - pasid support forces pass-through support to 1.
// - bit 4 is 0 for 8-bit and 1 for 32-bit ids, default 0.
// - bit 3 reports interrupt remapping, which needs queued invalidation.
// - bit 2 reports device tlb, needs queued inv, forced by page requests.
// - bit 1 reports queued invalidation support.
// - bit 0 reports whether table and second-level fetches are snooped.
// - fault log, queues, semaphore and first-level fetches are snooped.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module recap_top
    import recap_pkg::*;
#(
    parameter bit WALK_SNOOPED = 1'b1,
    parameter bit QUEUED_INV = 1'b1,
    parameter bit DEVICE_TLB = 1'b1,
    parameter bit INTR_REMAP = 1'b1,
    parameter bit WIDE_INTR_ID = 1'b0,
    parameter bit PASS_THROUGH = 1'b1,
    parameter bit SNOOP_CTRL = 1'b1,
    parameter int IOTLB_OFS = 32,
    parameter int HANDLE_MASK = 15,
    parameter bit EXT_CONTEXT = 1'b1,
    parameter bit MEM_TYPE = 1'b1,
    parameter bit PAGE_REQ = 1'b0,
    parameter bit PASID = 1'b0,
    parameter bit COHERENT_SCOPE = 1'b0
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // fetch attributes to the walker
    output logic o_walk_snoop,
    output logic o_aux_snoop,
    // iotlb group location
    output logic [IOTLB_BASE_W-1:0] o_iotlb_base
);

    // elaboration checks: refuse combinations the capability cannot report
    if (IOTLB_OFS < 0 || IOTLB_OFS >= (1 << IOTLB_OFS_W)) begin : g_bad_iro
        $error("iotlb offset does not fit its field");
    end
    if (HANDLE_MASK < 0 || HANDLE_MASK >= (1 << HANDLE_MASK_W))
    begin : g_bad_mask
        $error("handle mask does not fit its field");
    end
    if (COHERENT_SCOPE && !MEM_TYPE) begin : g_bad_mts
        $error("coherent scope needs memory type support");
    end
    if ((PASID || PAGE_REQ) && !EXT_CONTEXT) begin : g_bad_ecs
        $error("pasid or page requests need extended context");
    end
    if (PASID && !PASS_THROUGH) begin : g_bad_pt
        $error("pasid needs pass-through support");
    end
    if (INTR_REMAP && !QUEUED_INV) begin : g_bad_ir
        $error("interrupt remapping needs queued invalidation");
    end
    if (DEVICE_TLB && !QUEUED_INV) begin : g_bad_dt
        $error("device tlb needs queued invalidation");
    end
    if (PAGE_REQ && !DEVICE_TLB) begin : g_bad_prs
        $error("page requests need device tlb support");
    end
    if ((IOTLB_OFS << IOTLB_UNIT_SHIFT) < 32'h0000_0100 && IOTLB_OFS != 0)
    begin : g_bad_iotlb_overlap
        $error("iotlb group overlaps the base register block");
    end

    // register map and field layout the decode and mux rely on
    if (DATA_W != 32) begin : g_bad_dw
        $error("read mux serves a 32-bit port only");
    end
    if (ADDR_W < 6) begin : g_bad_aw
        $error("address too narrow for the status word");
    end
    if (RDATA_RST != '0) begin : g_bad_idle
        $error("idle read data must be zero");
    end
    if (STAT_RST != '0) begin : g_bad_stat_rst
        $error("status flags must come up clear");
    end
    if ((1 << IOTLB_UNIT_SHIFT) != 16) begin : g_bad_unit
        $error("iotlb group spacing must be sixteen bytes");
    end
    if (OFS_CAP_LO[1:0] != 2'h0 || OFS_CAP_HI[1:0] != 2'h0 ||
        OFS_ACC_STAT[1:0] != 2'h0) begin : g_bad_align
        $error("register offsets must be word aligned");
    end
    if (OFS_CAP_HI != OFS_CAP_LO + 12'h004) begin : g_bad_hi_ofs
        $error("high capability word must follow the low word");
    end
    if (OFS_ACC_STAT == OFS_CAP_LO || OFS_ACC_STAT == OFS_CAP_HI)
    begin : g_bad_stat_ofs
        $error("status word overlaps the capability words");
    end
    if (STAT_W > DATA_W || POS_STAT_RO_WRITE >= STAT_W ||
        POS_STAT_UNMAPPED >= STAT_W) begin : g_bad_stat_w
        $error("status flags do not fit the status word");
    end
    if (IOTLB_BASE_W != IOTLB_OFS_W + IOTLB_UNIT_SHIFT) begin : g_bad_base_w
        $error("iotlb base width disagrees with its field");
    end
    if (POS_IOTLB_OFS_LO + IOTLB_OFS_W > POS_HANDLE_MASK_LO)
    begin : g_bad_iro_pos
        $error("iotlb offset field runs into the handle mask");
    end
    if (POS_HANDLE_MASK_LO + HANDLE_MASK_W > POS_EXT_CONTEXT)
    begin : g_bad_mask_pos
        $error("handle mask field runs into extended context");
    end
    if (POS_PASID > 63 || POS_PAGE_REQ > 63) begin : g_bad_pos
        $error("capability bit beyond the 64-bit value");
    end

    localparam logic [IOTLB_OFS_W-1:0] IOTLB_OFS_F =
        IOTLB_OFS_W'(IOTLB_OFS);
    localparam logic [HANDLE_MASK_W-1:0] HANDLE_MASK_F =
        HANDLE_MASK_W'(HANDLE_MASK);
    // only meaningful with interrupt remapping; hidden as zero otherwise
    localparam logic [HANDLE_MASK_W-1:0] HANDLE_MASK_R =
        INTR_REMAP ? HANDLE_MASK_F : '0;
    localparam bit WIDE_INTR_ID_R = INTR_REMAP & WIDE_INTR_ID;

    // one where a field lives; every other bit is reserved and reads zero
    function automatic logic [63:0] field_mask();
        logic [63:0] m;
        m = '0;
        m[POS_WALK_SNOOPED] = 1'b1;
        m[POS_QUEUED_INV] = 1'b1;
        m[POS_DEVICE_TLB] = 1'b1;
        m[POS_INTR_REMAP] = 1'b1;
        m[POS_WIDE_INTR_ID] = 1'b1;
        m[POS_PASS_THROUGH] = 1'b1;
        m[POS_SNOOP_CTRL] = 1'b1;
        m[POS_IOTLB_OFS_LO +: IOTLB_OFS_W] = '1;
        m[POS_HANDLE_MASK_LO +: HANDLE_MASK_W] = '1;
        m[POS_EXT_CONTEXT] = 1'b1;
        m[POS_MEM_TYPE] = 1'b1;
        m[POS_PAGE_REQ] = 1'b1;
        m[POS_PASID] = 1'b1;
        return m;
    endfunction
    localparam logic [63:0] FIELD_MASK = field_mask();

    // a field placed over another would double-report a bit
    if ($countones(FIELD_MASK) != 11 + IOTLB_OFS_W + HANDLE_MASK_W)
    begin : g_bad_overlap
        $error("two capability fields share a bit");
    end
    if ((CAP_RST & ~FIELD_MASK) != 64'h0) begin : g_bad_rst
        $error("capability reset value sets a reserved bit");
    end

    logic [63:0] cap;
    logic [63:0] cap_rd;
    logic [DATA_W-1:0] cap_word [2];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;
    logic walk_snoop_r;
    logic aux_snoop_r;
    logic [IOTLB_BASE_W-1:0] iotlb_base_r;
    logic hit_lo;
    logic hit_hi;
    logic hit_stat;
    logic mapped;

    recap_fields #(
        .WALK_SNOOPED(WALK_SNOOPED),
        .QUEUED_INV(QUEUED_INV),
        .DEVICE_TLB(DEVICE_TLB),
        .INTR_REMAP(INTR_REMAP),
        .WIDE_INTR_ID(WIDE_INTR_ID_R),
        .PASS_THROUGH(PASS_THROUGH),
        .SNOOP_CTRL(SNOOP_CTRL),
        .IOTLB_OFS(IOTLB_OFS_F),
        .HANDLE_MASK(HANDLE_MASK_R),
        .EXT_CONTEXT(EXT_CONTEXT),
        .MEM_TYPE(MEM_TYPE),
        .PAGE_REQ(PAGE_REQ),
        .PASID(PASID)
    ) u_fields (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .o_cap(cap)
    );

    // reserved bits read zero whatever the fields module holds
    for (genvar b = 0; b < 64; b++) begin : g_rsvd
        if (FIELD_MASK[b]) begin : g_live
            assign cap_rd[b] = cap[b];
        end else begin : g_zero
            assign cap_rd[b] = 1'b0;
        end
    end

    // the two port words of the 64-bit value, low word first
    for (genvar w = 0; w < 2; w++) begin : g_word
        assign cap_word[w] = cap_rd[w*DATA_W +: DATA_W];
    end

    // address decode; sub-word addresses are not mapped
    assign hit_lo = (i_addr == OFS_CAP_LO);
    assign hit_hi = (i_addr == OFS_CAP_HI);
    assign hit_stat = (i_addr == OFS_ACC_STAT);
    assign mapped = hit_lo | hit_hi | hit_stat;

    // read mux; unmapped reads return zero
    always_comb begin
        rdata_nxt = RDATA_RST;
        if (i_rd) begin
            if (hit_lo) begin
                rdata_nxt = cap_word[0];
            end else if (hit_hi) begin
                rdata_nxt = cap_word[1];
            end else if (hit_stat) begin
                rdata_nxt = {{(DATA_W-STAT_W){1'b0}}, stat_r};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_r <= RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // a write to the capability words is dropped and only flagged
    always_comb begin
        stat_set = '0;
        stat_set[POS_STAT_RO_WRITE] = i_wr & (hit_lo | hit_hi);
        stat_set[POS_STAT_UNMAPPED] = (i_wr | i_rd) & ~mapped;
        stat_clr = (i_wr & hit_stat) ? i_wdata[STAT_W-1:0] : '0;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_r <= STAT_RST;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | stat_set;
        end
    end

    // fetch attributes follow the fixed capability, not software
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            walk_snoop_r <= 1'b0;
        end else begin
            walk_snoop_r <= cap[POS_WALK_SNOOPED];
        end
    end

    // coherent whatever the walk bit says, in reset too
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aux_snoop_r <= 1'b1;
        end else begin
            aux_snoop_r <= 1'b1;
        end
    end

    // group base relative to unit base, sixteen bytes per unit
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            iotlb_base_r <= '0;
        end else begin
            iotlb_base_r <= {cap[POS_IOTLB_OFS_LO +: IOTLB_OFS_W],
                {IOTLB_UNIT_SHIFT{1'b0}}};
        end
    end

    assign o_rdata = rdata_r;
    assign o_walk_snoop = walk_snoop_r;
    assign o_aux_snoop = aux_snoop_r;
    assign o_iotlb_base = iotlb_base_r;

endmodule

// ### tb/recap_checker.sv
// recap_checker: concurrent checks on the capability register port.
// assumes it is bound to recap_top and sees only its ports.
`timescale 1ns/1ns
module recap_checker
    import recap_pkg::*;
#(
    parameter int IOTLB_OFS = 32,
    parameter bit WALK_SNOOPED = 1'b1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    // fixed outputs
    input wire logic o_walk_snoop,
    input wire logic o_aux_snoop,
    input wire logic [IOTLB_BASE_W-1:0] o_iotlb_base
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // fixed outputs settle on the second edge after release
    logic [1:0] up_cnt;
    logic rd_lo;
    logic rd_unmapped;
    assign rd_lo = i_rd && i_addr == OFS_CAP_LO && up_cnt >= 2'h2;
    assign rd_unmapped = i_rd && !(i_addr inside
        {OFS_CAP_LO, OFS_CAP_HI, OFS_ACC_STAT});
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    unmapped_rd_zero_a: assert property (
        rd_unmapped |=> o_rdata == 32'h0)
        else $error("unmapped read returned data");
    rdata_idle_zero_a: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    iotlb_base_a: assert property (up_cnt >= 2'h2 |->
        o_iotlb_base == IOTLB_BASE_W'(IOTLB_OFS * 16))
        else $error("iotlb group location wrong");
    walk_snoop_a: assert property (up_cnt >= 2'h2 |->
        o_walk_snoop == WALK_SNOOPED)
        else $error("walk snoop attribute wrong");
    aux_snoop_a: assert property (o_aux_snoop)
        else $error("auxiliary fetches not coherent");
    rd_walk_bit_a: assert property (
        rd_lo |=> o_rdata[0] == o_walk_snoop)
        else $error("walk coherency bit disagrees with walker");
    rd_iotlb_field_a: assert property (rd_lo |=>
        {o_rdata[17:8], 4'h0} == o_iotlb_base)
        else $error("iotlb offset field disagrees with location");
    ext_ctx_need_a: assert property (rd_lo |=>
        !o_rdata[29] || (o_rdata[24] && o_rdata[2]))
        else $error("page requests without ext context or device tlb");
    qi_needed_a: assert property (rd_lo |=>
        !(o_rdata[3] || o_rdata[2]) || o_rdata[1])
        else $error("remap or device tlb without queued invalidation");
endmodule

// ### tb/recap_top_tb.sv
// recap_top_tb: drives the register port, checks reads through a queue.
// assumes recap_top with default parameters.
`timescale 1ns/1ns
module recap_top_tb
    import recap_pkg::*;
;
    localparam logic [31:0] CAP_LO = 32'h03f0_20cf;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = 12'h000;
    logic [DATA_W-1:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic o_walk_snoop;
    logic o_aux_snoop;
    logic [IOTLB_BASE_W-1:0] o_iotlb_base;
    logic [31:0] exp_q[$];
    logic rd_seen = 1'b0;
    int failures = 0;
    int n_compared = 0;

    recap_top uut (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_walk_snoop(o_walk_snoop),
        .o_aux_snoop(o_aux_snoop),
        .o_iotlb_base(o_iotlb_base)
    );

    initial begin
        forever #20 i_core_clk = ~i_core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    // expectation noted now, compared when the answer cycle comes
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask

    // sampled mid-cycle so design updates have landed
    always @(negedge i_core_clk) begin
        if (rd_seen === 1'b1) begin
            check(o_rdata, exp_q.pop_front());
        end
        rd_seen = i_rd;
    end

    initial begin
        #(40 * 5000);
        failures++;
        tally_and_finish;
    end

    initial begin
        logic [ADDR_W-1:0] a;
        void'($urandom(87322));
        repeat (12) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        rd(OFS_CAP_LO, CAP_LO);
        rd(OFS_CAP_HI, 32'h0);
        rd(OFS_ACC_STAT, 32'h0);
        check({18'h0, o_iotlb_base}, 32'h0000_0200);
        check({31'h0, o_walk_snoop}, 32'h1);
        check({31'h0, o_aux_snoop}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(i[0] ? OFS_CAP_HI : OFS_CAP_LO, $urandom());
            rd(OFS_CAP_LO, CAP_LO);
            rd(OFS_CAP_HI, 32'h0);
            rd(OFS_ACC_STAT, 32'h1);
            wr(OFS_ACC_STAT, 32'h1);
            rd(OFS_ACC_STAT, 32'h0);
            // random unmapped word; a mapped hit is moved away
            a = 12'($urandom()) & 12'hffc;
            if (a inside {OFS_CAP_LO, OFS_CAP_HI, OFS_ACC_STAT}) begin
                a = 12'h100;
            end
            rd(a, 32'h0);
            rd(OFS_ACC_STAT, 32'h2);
            wr(OFS_ACC_STAT, 32'h3);
        end
        repeat (2) @(posedge i_core_clk);
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        rd(OFS_CAP_LO, CAP_LO);
        rd(OFS_ACC_STAT, 32'h0);
        repeat (3) @(posedge i_core_clk);
        tally_and_finish;
    end
endmodule

bind recap_top recap_checker #(
    .IOTLB_OFS(IOTLB_OFS),
    .WALK_SNOOPED(WALK_SNOOPED)
) chk (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_walk_snoop(o_walk_snoop),
    .o_aux_snoop(o_aux_snoop),
    .o_iotlb_base(o_iotlb_base)
);
